// file: shared/mst_regs.svh
// constants for the module management timing block: status bit position,
// pin idle levels, every latency as a time, and init, reset pulse and wake also as a cycle count.
// assumes a single 100 MHz management clock.
`ifndef MST_REGS_SVH
`define MST_REGS_SVH

// ----------------------------------------------------------------------
// status byte layout
// ----------------------------------------------------------------------
`define MST_STATUS_BYTE 8'h02
`define MST_DNR_BIT 0
`define MST_STATUS_RST 8'h01

// ----------------------------------------------------------------------
// pin idle levels, order {reset_n, select_n, lp_req}
// ----------------------------------------------------------------------
`define MST_PIN_IDLE 3'h6

// ----------------------------------------------------------------------
// timing, times as printed, counts derived at 100 cycles per us
// ----------------------------------------------------------------------
`define MST_CYC_PER_US 100
`define MST_T_INIT_MS 2000
`define MST_T_RSTPULSE_US 2
`define MST_T_LOW_POWER_REQUEST_US 100
`define MST_T_INT_ON_MS 200
`define MST_T_INT_OFF_US 500
`define MST_T_MASK_MS 100
`define MST_T_SELECT_US 100
`define MST_T_PDOWN_ON_MS 100
`define MST_T_PDOWN_OFF_MS 300
`define MST_INIT_CYC (`MST_T_INIT_MS * 1000 * `MST_CYC_PER_US)
`define MST_RSTPULSE_CYC (`MST_T_RSTPULSE_US * `MST_CYC_PER_US)
`define MST_WAKE_CYC (`MST_T_PDOWN_OFF_MS * 1000 * `MST_CYC_PER_US)

`endif

// file: shared/mst_pkg.sv
// types for the module management timing block.
// assumes nothing of its surroundings.
package mst_pkg;

   // ------------------------------------------------------------------
   // pins from the host, first member is the top bit
   // ------------------------------------------------------------------
   typedef struct packed {
      logic reset_n;
      logic select_n;
      logic lp_req;
   } mst_pins_t;

   // ------------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      MST_HOLD,
      MST_INIT,
      MST_RUN,
      MST_LOWP,
      MST_WAKE
   } mst_state_t;

endpackage : mst_pkg

// file: logic/mst_mgmt_timing.sv
// management control and status sequencing of a pluggable module:
// init after power-on or reset, data-not-ready, flags and interrupt,
// masks, select gating of the serial bus and low-power control.
// assumes the serial bus engine sits on ref_clk and hands over strobes
// at the rising clock edge after each stop bit.
//
// Contract
// - fully functional within 2000 ms of power-on
// - reset pin recognised only when low over 2 us
// - serial bus answers within 2000 ms of power-on
// - clear data-not-ready and assert interrupt after init
// - fully functional once ready interrupt raised
// - fully functional within 2000 ms of reset release
// - low-power pin gives low power within 100 us
// - interrupt asserted within 200 ms of condition
// - flags clear on read, interrupt released quickly
// - loss-of-signal flag and interrupt within 100 ms
// - transmit fault flag and interrupt within 200 ms
// - other flags set with interrupt within 200 ms
// - set mask stops interrupt within 100 ms
// - cleared mask resumes interrupt within 100 ms
// - select asserted enables bus within 100 us
// - select deasserted disables bus within 100 us
// - power-down bit set gives low power
// - power-down bit cleared: functional within 300 ms
// - control writes take effect from stop edge
// - user page carries no imposed structure
`timescale 1ns/1ps
`default_nettype none
`include "mst_regs.svh"

module mst_mgmt_timing #(
   parameter int NFLAG = 3,
   parameter int INIT_CYC = `MST_INIT_CYC,
   parameter int WAKE_CYC = `MST_WAKE_CYC,
   parameter int RST_MIN_CYC = `MST_RSTPULSE_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire mst_pkg::mst_pins_t pins,
   input wire logic [NFLAG-1:0] flag_cond,
   input wire logic flag_read,
   input wire logic [NFLAG-1:0] flag_read_sel,
   input wire logic status_read,
   input wire logic ctrl_write,
   input wire logic [NFLAG-1:0] mask_wdata,
   input wire logic pdown_wdata,
   output logic interrupt_out_n,
   output logic bus_enable,
   output logic low_power,
   output logic fully_functional,
   output logic [7:0] status_byte,
   output logic [NFLAG-1:0] flags,
   output logic [NFLAG-1:0] mask,
   output logic pdown
);

   // ------------------------------------------------------------------
   // local widths and counts
   // ------------------------------------------------------------------
   localparam int CW = 28;
   localparam int RW = 16;
   localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYC - 1);
   localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYC - 1);
   localparam logic [RW-1:0] RST_MIN = RW'(RST_MIN_CYC);

   // ------------------------------------------------------------------
   // pin synchronisers, three stages, filtered on stages two and three
   // ------------------------------------------------------------------
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [2:0] pin_s3;
   logic [2:0] pin_filt;
   logic [2:0] next_pin_filt;
   logic rst_pin_n;
   logic sel_pin_n;
   logic lp_pin;

   always_comb begin
      next_pin_filt = (pin_s2 & pin_s3) | (pin_filt & (pin_s2 ^ pin_s3));
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= `MST_PIN_IDLE;
         pin_s2 <= `MST_PIN_IDLE;
         pin_s3 <= `MST_PIN_IDLE;
         pin_filt <= `MST_PIN_IDLE;
      end else begin
         pin_s1 <= pins;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_filt <= next_pin_filt;
      end
   end

   assign rst_pin_n = pin_filt[2];
   assign sel_pin_n = pin_filt[1];
   assign lp_pin = pin_filt[0];

   // ------------------------------------------------------------------
   // reset pulse qualification
   // ------------------------------------------------------------------
   logic [RW-1:0] rlow_cnt;
   logic [RW-1:0] next_rlow_cnt;
   logic rst_hit;

   always_comb begin
      next_rlow_cnt = rlow_cnt;
      if (rst_pin_n) begin
         next_rlow_cnt = '0;
      end else if (rlow_cnt <= RST_MIN) begin
         next_rlow_cnt = rlow_cnt + RW'(1);
      end
   end

   // only a low level longer than the minimum pulse counts
   assign rst_hit = (rlow_cnt > RST_MIN);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rlow_cnt <= '0;
      end else begin
         rlow_cnt <= next_rlow_cnt;
      end
   end

   // ------------------------------------------------------------------
   // control bits, taken at the stop edge of a control write
   // ------------------------------------------------------------------
   logic [NFLAG-1:0] next_mask;
   logic next_pdown;

   always_comb begin
      next_mask = mask;
      next_pdown = pdown;
      if (rst_hit) begin
         next_mask = '0;
         next_pdown = 1'b0;
      end else if (ctrl_write) begin
         next_mask = mask_wdata;
         next_pdown = pdown_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= '0;
         pdown <= 1'b0;
      end else begin
         mask <= next_mask;
         pdown <= next_pdown;
      end
   end

   // ------------------------------------------------------------------
   // sequencer with the long latency counter
   // ------------------------------------------------------------------
   mst_pkg::mst_state_t state;
   mst_pkg::mst_state_t next_state;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic init_done;

   always_comb begin
      next_state = state;
      next_cnt = '0;
      init_done = 1'b0;
      case (state)
         mst_pkg::MST_HOLD: begin
            if (rst_pin_n) begin
               next_state = mst_pkg::MST_INIT;
            end
         end
         mst_pkg::MST_INIT: begin
            // one counter covers the two second window
            next_cnt = cnt + CW'(1);
            if (cnt == INIT_LAST) begin
               next_state = mst_pkg::MST_RUN;
               init_done = 1'b1;
               next_cnt = '0;
            end
         end
         mst_pkg::MST_RUN: begin
            if (pdown) begin
               next_state = mst_pkg::MST_LOWP;
            end
         end
         mst_pkg::MST_LOWP: begin
            if (!pdown) begin
               next_state = mst_pkg::MST_WAKE;
            end
         end
         mst_pkg::MST_WAKE: begin
            next_cnt = cnt + CW'(1);
            if (pdown) begin
               next_state = mst_pkg::MST_LOWP;
               next_cnt = '0;
            end else if (cnt == WAKE_LAST) begin
               next_state = mst_pkg::MST_RUN;
               next_cnt = '0;
            end
         end
         default: begin
            next_state = mst_pkg::MST_HOLD;
         end
      endcase
      if (rst_hit) begin
         next_state = mst_pkg::MST_HOLD;
         next_cnt = '0;
         init_done = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= mst_pkg::MST_INIT;
         cnt <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ------------------------------------------------------------------
   // flags, ready event and interrupt
   // ------------------------------------------------------------------
   logic [NFLAG-1:0] cond_q;
   logic [NFLAG-1:0] flag_rise;
   logic [NFLAG-1:0] flag_clr;
   logic [NFLAG-1:0] next_flags;
   logic ready_evt;
   logic next_ready_evt;
   logic next_int_n;

   assign flag_rise = flag_cond & ~cond_q;
   assign flag_clr = flag_read ? flag_read_sel : '0;

   always_comb begin
      // a new event in the clearing cycle survives the clear
      next_flags = (flags & ~flag_clr) | flag_rise;
      next_ready_evt = (ready_evt & ~status_read) | init_done;
      if (rst_hit) begin
         next_flags = '0;
         next_ready_evt = 1'b0;
      end
      // unmasked flags and the ready event drive the pin low
      next_int_n = ~((|(next_flags & ~next_mask)) | next_ready_evt);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_q <= '0;
         flags <= '0;
         ready_evt <= 1'b0;
         interrupt_out_n <= 1'b1;
      end else begin
         cond_q <= flag_cond;
         flags <= next_flags;
         ready_evt <= next_ready_evt;
         interrupt_out_n <= next_int_n;
      end
   end

   // ------------------------------------------------------------------
   // status byte, bus gating, power level
   // ------------------------------------------------------------------
   logic [7:0] next_status;
   logic next_bus_enable;
   logic next_low_power;
   logic next_ff;
   logic up;

   always_comb begin
      up = (next_state != mst_pkg::MST_HOLD) &&
           (next_state != mst_pkg::MST_INIT);
      next_status = '0; // user storage lies elsewhere, unshaped
      next_status[`MST_DNR_BIT] = ~up;
      // bus answers only once up and while selected
      next_bus_enable = up && !sel_pin_n;
      next_low_power = lp_pin || (next_state == mst_pkg::MST_LOWP);
      next_ff = (next_state == mst_pkg::MST_RUN);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_byte <= `MST_STATUS_RST;
         bus_enable <= 1'b0;
         low_power <= 1'b0;
         fully_functional <= 1'b0;
      end else begin
         status_byte <= next_status;
         bus_enable <= next_bus_enable;
         low_power <= next_low_power;
         fully_functional <= next_ff;
      end
   end

endmodule : mst_mgmt_timing
`default_nettype wire

// file: tb/mst_host.sv
// host model: drives the module pins and the bus stop strobes.
// assumes one ref_clk; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module mst_host (
   input wire logic ref_clk,
   output var mst_pkg::mst_pins_t pins,
   output logic flag_read,
   output logic [2:0] flag_read_sel,
   output logic status_read,
   output logic ctrl_write,
   output logic [2:0] mask_wdata,
   output logic pdown_wdata
);
   // ----
   // each strobe marks the edge after a stop bit
   // ----
   initial begin
      pins = 3'h6;
      {flag_read, flag_read_sel, status_read} = 5'h00;
      {ctrl_write, mask_wdata, pdown_wdata} = 5'h00;
   end
   task rd_flags(input logic [2:0] sel);
      @(posedge ref_clk);
      flag_read <= 1'h1;
      flag_read_sel <= sel;
      @(posedge ref_clk);
      flag_read <= 1'h0;
   endtask : rd_flags
   task rd_status;
      @(posedge ref_clk);
      status_read <= 1'h1;
      @(posedge ref_clk);
      status_read <= 1'h0;
   endtask : rd_status
   task wr_ctrl(input logic [2:0] m, input logic p);
      @(posedge ref_clk);
      ctrl_write <= 1'h1;
      mask_wdata <= m;
      pdown_wdata <= p;
      @(posedge ref_clk);
      ctrl_write <= 1'h0;
   endtask : wr_ctrl
   task set_pins(input logic sel_n, input logic lp);
      @(posedge ref_clk);
      pins.select_n <= sel_n;
      pins.lp_req <= lp;
   endtask : set_pins
   task pin_low(input int n);
      @(posedge ref_clk);
      pins.reset_n <= 1'h0;
      repeat (n) @(posedge ref_clk);
      pins.reset_n <= 1'h1;
   endtask : pin_low
endmodule : mst_host
`default_nettype wire

// file: tb/mst_chk_assertions.sv
// checker for the management timing block.
// assumes it is bound onto each mst_mgmt_timing instance.
`timescale 1ns/1ps
`default_nettype none
module mst_chk #(
   parameter int NFLAG = 3,
   parameter int INIT_CYC = 50,
   parameter int WAKE_CYC = 20,
   parameter int RST_MIN_CYC = 4
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire mst_pkg::mst_pins_t pins,
   input wire logic [NFLAG-1:0] flag_cond,
   input wire logic flag_read,
   input wire logic [NFLAG-1:0] flag_read_sel,
   input wire logic ctrl_write,
   input wire logic [NFLAG-1:0] mask_wdata,
   input wire logic pdown_wdata,
   input wire logic interrupt_out_n,
   input wire logic bus_enable,
   input wire logic low_power,
   input wire logic fully_functional,
   input wire logic [7:0] status_byte,
   input wire logic [NFLAG-1:0] flags,
   input wire logic [NFLAG-1:0] mask,
   input wire logic pdown
);
   localparam int INIT_MAX = INIT_CYC + 6;
   localparam int WAKE_MAX = WAKE_CYC + 6;
   logic [NFLAG-1:0] cond_q;
   wire logic [NFLAG-1:0] rise = flag_cond & ~cond_q;
   wire logic ff = fully_functional;
   // ----
   // properties
   // ----
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cond_q <= '0;
      else cond_q <= flag_cond;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_init;
      $rose(rst_n) |-> ##[1:INIT_MAX] ff;
   endproperty
   a_init: assert property (p_init) else $error("init too slow");
   property p_ready;
      $rose(ff) && $past(status_byte[0])
         |-> status_byte == 8'h00 && !interrupt_out_n;
   endproperty
   a_ready: assert property (p_ready) else $error("bad ready");
   property p_flag;
      ff && |rise |=> (flags & $past(rise)) == $past(rise);
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set");
   property p_int;
      ff && |(rise & ~mask) && !ctrl_write |=> !interrupt_out_n;
   endproperty
   a_int: assert property (p_int) else $error("no interrupt");
   property p_clear;
      flag_read && !(|rise) |=> (flags & $past(flag_read_sel)) == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("not cleared");
   property p_ctrl;
      ctrl_write |=> mask == $past(mask_wdata) && pdown == $past(pdown_wdata);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("ctrl not taken");
   property p_unmask;
      ctrl_write && !flag_read && ff && |(flags & ~mask_wdata)
         |=> !interrupt_out_n;
   endproperty
   a_unmask: assert property (p_unmask) else $error("no resume");
   property p_pdown;
      ctrl_write && pdown_wdata |-> ##[1:2] low_power;
   endproperty
   a_pdown: assert property (p_pdown) else $error("no low power");
   property p_wake;
      $fell(pdown) && $past(ctrl_write) |-> ##[1:WAKE_MAX] ff;
   endproperty
   a_wake: assert property (p_wake) else $error("wake too slow");
   property p_sel_off;
      $rose(pins.select_n) |-> ##[1:8] !bus_enable;
   endproperty
   a_sel_off: assert property (p_sel_off) else $error("bus on");
   property p_lp;
      $rose(pins.lp_req) |-> ##[1:8] low_power;
   endproperty
   a_lp: assert property (p_lp) else $error("pin low power");
   c_pdown: cover property (ctrl_write && pdown_wdata);
   c_up: cover property ($rose(ff));
   c_int: cover property ($fell(interrupt_out_n) && |flags);
endmodule : mst_chk
bind mst_mgmt_timing mst_chk #(.NFLAG(NFLAG), .INIT_CYC(INIT_CYC),
   .WAKE_CYC(WAKE_CYC), .RST_MIN_CYC(RST_MIN_CYC)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .flag_cond(flag_cond),
   .flag_read(flag_read), .flag_read_sel(flag_read_sel),
   .ctrl_write(ctrl_write), .mask_wdata(mask_wdata),
   .pdown_wdata(pdown_wdata), .interrupt_out_n(interrupt_out_n),
   .bus_enable(bus_enable), .low_power(low_power),
   .fully_functional(fully_functional), .status_byte(status_byte),
   .flags(flags), .mask(mask), .pdown(pdown));
`default_nettype wire

// file: tb/mst_mgmt_timing_tb_top.sv
// bench for the management timing block with the host model.
// assumes short init, wake and reset-pulse counts.
`timescale 1ns/1ps
`default_nettype none
module mst_mgmt_timing_tb_top;
   logic ref_clk;
   logic rst_n;
   logic [2:0] flag_cond;
   mst_pkg::mst_pins_t pins;
   logic flag_read, status_read, ctrl_write, pdown_wdata, pdown;
   logic [2:0] flag_read_sel, mask_wdata, flags, mask;
   logic interrupt_out_n, bus_enable, low_power, fully_functional;
   logic [7:0] status_byte;
   localparam int INIT_N = 50;
   localparam int WAKE_N = 20;
   localparam int RMIN_N = 4;
   int err_total = 0;
   int n_tests = 0;
   mst_host host (.ref_clk(ref_clk), .pins(pins), .flag_read(flag_read),
      .flag_read_sel(flag_read_sel), .status_read(status_read),
      .ctrl_write(ctrl_write), .mask_wdata(mask_wdata),
      .pdown_wdata(pdown_wdata));
   mst_mgmt_timing #(.INIT_CYC(INIT_N), .WAKE_CYC(WAKE_N),
      .RST_MIN_CYC(RMIN_N)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
      .flag_cond(flag_cond), .flag_read(flag_read),
      .flag_read_sel(flag_read_sel), .status_read(status_read),
      .ctrl_write(ctrl_write), .mask_wdata(mask_wdata),
      .pdown_wdata(pdown_wdata), .interrupt_out_n(interrupt_out_n),
      .bus_enable(bus_enable), .low_power(low_power),
      .fully_functional(fully_functional), .status_byte(status_byte),
      .flags(flags), .mask(mask), .pdown(pdown));
   // ----
   // helpers
   // ----
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   task chk(input logic seen, input logic exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %b", $time, seen);
      end
   endtask : chk
   task stop_test;
      if (err_total == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   task wait_ff(input int n);
      for (int i = 0; i < n && fully_functional !== 1'h1; i++) tick(1);
      if (fully_functional !== 1'h1) begin
         err_total++;
         stop_test();
      end
   endtask : wait_ff
   task set_cond(input logic [2:0] v);
      @(posedge ref_clk);
      flag_cond <= v;
   endtask : set_cond
   initial begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      rst_n = 1'h0;
      flag_cond = 3'h0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'h1;
      wait_ff(70);
      chk(status_byte === 8'h00, 1'h1);
      chk(interrupt_out_n, 1'h0);
      host.rd_status();
      tick(2);
      chk(interrupt_out_n, 1'h1);
      host.set_pins(1'h0, 1'h0);
      tick(8);
      chk(bus_enable, 1'h1);
      host.set_pins(1'h1, 1'h0);
      tick(8);
      chk(bus_enable, 1'h0);
      for (int k = 0; k < 3; k++) begin
         set_cond(3'h1 << k);
         tick(2);
         chk(flags[k] & ~interrupt_out_n, 1'h1);
         host.rd_flags(3'h1 << k);
         tick(2);
         chk(flags === 3'h0 && interrupt_out_n, 1'h1);
      end
      set_cond(3'h0);
      host.wr_ctrl(3'h1, 1'h0);
      tick(0);
      chk(mask === 3'h1 && pdown === 1'h0, 1'h1);
      set_cond(3'h1);
      tick(2);
      chk(flags[0] & interrupt_out_n, 1'h1);
      host.wr_ctrl(3'h0, 1'h0);
      tick(1);
      chk(interrupt_out_n, 1'h0);
      host.rd_flags(3'h7);
      tick(2);
      chk(interrupt_out_n, 1'h1);
      host.wr_ctrl(3'h0, 1'h1);
      tick(2);
      chk(low_power & ~fully_functional, 1'h1);
      chk(pdown, 1'h1);
      host.wr_ctrl(3'h0, 1'h0);
      wait_ff(30);
      chk(low_power, 1'h0);
      host.set_pins(1'h1, 1'h1);
      tick(8);
      chk(low_power, 1'h1);
      host.set_pins(1'h1, 1'h0);
      host.pin_low(2);
      tick(10);
      chk(fully_functional, 1'h1);
      host.pin_low(12);
      tick(1);
      chk(fully_functional, 1'h0);
      wait_ff(70);
      chk(status_byte === 8'h00, 1'h1);
      stop_test();
   end
endmodule : mst_mgmt_timing_tb_top
`default_nettype wire
